/* common/acs_pkg.sv */
// Functional notes
// - Continuous mode drives the two address lines with the current channel index.
// - Readable result in continuous mode belongs to the channel before the shown one.
// - Continuous mode changes address outputs only on mode entry and when busy rises at conversion end.
// - Manual mode latches the host channel code when a conversion starts.
// - Manual mode acquires the latched channel once the conversion completes.
// - Power-down switches analog circuits off while digital logic keeps working.
// - During power-down the last conversion result stays readable; a conversion that ends overwrites it.
// - A convert while powered down may run; nothing is flagged, result meaningless.
// - Continuous select makes address pins outputs and cycles all four channels.
// - Continuous counter advances each conversion end, from last manual address plus one.
// - A power-down pulse of minimum width zeroes the channel counter on release.
// - Convert commands during a conversion are ignored.
package acs_pkg;
    // Register byte offsets
    localparam logic [4:0] ACS_REG_STATUS = 5'h00;
    localparam logic [4:0] ACS_REG_RESULT = 5'h04;
    localparam logic [4:0] ACS_REG_CONTROL = 5'h08;
    localparam logic [4:0] ACS_REG_CHRES0 = 5'h10;
    localparam logic [4:0] ACS_REG_CHRES3 = 5'h1C;
    // Field positions
    localparam int ACS_ST_BUSY = 0;
    localparam int ACS_ST_CONT = 1;
    localparam int ACS_ST_PD = 2;
    localparam int ACS_ST_SETTLE = 3;
    localparam int ACS_ST_CHAN_LO = 4;
    localparam int ACS_RES_CHAN_LO = 16;
    localparam int ACS_CTL_CONVERT = 0;
    // Reset values
    localparam logic [15:0] ACS_RESULT_RST = 16'h0000;
    localparam logic [1:0] ACS_CHAN_RST = 2'h0;
    localparam logic [1:0] ACS_CHAN_LAST = 2'h3;
    // Timing
    localparam int ACS_CLK_NS = 20;
    localparam int ACS_CONV_NS = 8000;
    localparam int ACS_ACQ_NS = 2000;
    localparam int ACS_PD_MIN_NS = 200;
    localparam int ACS_SETTLE_MS = 1;
    localparam int ACS_CONV_CYC = ACS_CONV_NS / ACS_CLK_NS;
    localparam int ACS_ACQ_CYC = (ACS_ACQ_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    localparam int ACS_PD_MIN_CYC = (ACS_PD_MIN_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    localparam int ACS_SETTLE_CYC = ACS_SETTLE_MS * 1000000 / ACS_CLK_NS;
    localparam int ACS_TMR_W = 16;
    // Bus answer sequencing
    localparam logic [1:0] ACS_BUS_IDLE = 2'h0;
    localparam logic [1:0] ACS_BUS_FETCH = 2'h1;
    localparam logic [1:0] ACS_BUS_ACK = 2'h2;
    // Conversion states, Gray along idle, convert, acquire
    typedef enum logic [1:0]
    {
        ACS_IDLE = 2'b00,
        ACS_CONV = 2'b01,
        ACS_ACQ = 2'b11
    } acs_state_e;
endpackage : acs_pkg

/* logic/acs_result_mem.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Per-channel store of the latest result, registered read port
module acs_result_mem
(
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic [1:0] i_rd_addr,
    output logic [15:0] o_rd_data
);
    logic [15:0] mem_r [4];

    // One write port
    always_ff @(posedge i_clk)
    begin
        if (i_wr_en)
            mem_r[i_wr_addr] <= i_wr_data;
    end

    // Read data from a register
    always_ff @(posedge i_clk)
    begin
        o_rd_data <= mem_r[i_rd_addr];
    end
endmodule : acs_result_mem

/* logic/acs_sequencer.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Four-channel converter sequencer with Avalon-MM register slave
module acs_sequencer
    import acs_pkg::*;
#(
    parameter logic [ACS_TMR_W-1:0] SETTLE_CYC = ACS_TMR_W'(ACS_SETTLE_CYC)
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Host pins
    input wire logic i_cs_n,
    input wire logic i_read_conv_n,
    input wire logic i_continuous_mode_sel,
    input wire logic i_power_down_in,
    input wire logic i_chan_addr_bit0,
    input wire logic i_chan_addr_bit1,
    output logic o_chan_addr_bit0,
    output logic o_chan_addr_bit1,
    output logic o_chan_addr_oe,
    output logic o_busy_n,
    // Converter core
    input wire logic [15:0] i_sample_data,
    output logic [1:0] o_analog_input_channel,
    output logic o_analog_power_en,
    // Avalon-MM slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);
    acs_state_e state_r;
    logic [ACS_TMR_W-1:0] tmr_r;
    logic [ACS_TMR_W-1:0] settle_r;
    logic [ACS_TMR_W-1:0] pd_cnt_r;
    logic [1:0] cur_chan_r;
    logic [1:0] next_chan_r;
    logic [1:0] conv_chan_r;
    logic [15:0] result_r;
    logic [1:0] result_chan_r;
    logic both_low_r;
    logic pd_r;
    logic cont_r;
    logic [1:0] bus_r;
    logic [15:0] mem_rd;
    logic pin_cmd;
    logic sw_cmd;
    logic run_ok;
    logic start;
    logic conv_end;
    logic pd_zero;
    logic cont_entry;
    logic bus_req;
    logic bus_wr;

    //////////////////////////////////////////////////////////////////////////
    // Command and event decode
    assign pin_cmd = ~i_cs_n & ~i_read_conv_n & ~both_low_r;
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_wr = i_avs_write & (bus_r == ACS_BUS_ACK);
    assign sw_cmd = bus_wr & (i_avs_address == ACS_REG_CONTROL)
        & i_avs_writedata[ACS_CTL_CONVERT];
    assign run_ok = i_continuous_mode_sel & ~i_cs_n & ~i_read_conv_n
        & ~i_power_down_in;
    // Commands are only taken with busy high
    assign start = (state_r != ACS_CONV)
        & (pin_cmd | sw_cmd | (run_ok & (state_r == ACS_IDLE)));
    assign conv_end = (state_r == ACS_CONV) && (tmr_r == '0);
    assign pd_zero = pd_r & ~i_power_down_in
        & (pd_cnt_r >= ACS_TMR_W'(ACS_PD_MIN_CYC));
    assign cont_entry = i_continuous_mode_sel & ~cont_r;

    //////////////////////////////////////////////////////////////////////////
    // Edge history of command, power-down and mode pins
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            both_low_r <= 1'b0;
            pd_r <= 1'b0;
            cont_r <= 1'b0;
        end
        else
        begin
            both_low_r <= ~i_cs_n & ~i_read_conv_n;
            pd_r <= i_power_down_in;
            cont_r <= i_continuous_mode_sel;
        end
    end

    // Conversion state machine and its timer
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r <= ACS_IDLE;
            tmr_r <= '0;
        end
        else
        begin
            case (state_r)
                ACS_IDLE, ACS_ACQ:
                begin
                    if (start)
                    begin
                        state_r <= ACS_CONV;
                        tmr_r <= ACS_TMR_W'(ACS_CONV_CYC - 1);
                    end
                    else if (state_r == ACS_ACQ)
                    begin
                        if (tmr_r == '0)
                            state_r <= ACS_IDLE;
                        else
                            tmr_r <= tmr_r - 1'b1;
                    end
                end
                ACS_CONV:
                begin
                    if (conv_end)
                    begin
                        state_r <= ACS_ACQ;
                        tmr_r <= ACS_TMR_W'(ACS_ACQ_CYC - 1);
                    end
                    else
                        tmr_r <= tmr_r - 1'b1;
                end
                default:
                begin
                    state_r <= ACS_IDLE;
                    tmr_r <= '0;
                end
            endcase
        end
    end

    // Busy pin, low through the conversion
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_busy_n <= 1'b1;
        else if (start)
            o_busy_n <= 1'b0;
        else if (conv_end)
            o_busy_n <= 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Channel selection: manual latch and continuous counter
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cur_chan_r <= ACS_CHAN_RST;
            next_chan_r <= ACS_CHAN_LAST;
            conv_chan_r <= ACS_CHAN_RST;
        end
        else
        begin
            if (pd_zero)
            begin
                cur_chan_r <= ACS_CHAN_RST;
                next_chan_r <= ACS_CHAN_LAST;
            end
            else if (cont_entry)
                cur_chan_r <= next_chan_r + 2'd1;
            else if (conv_end)
            begin
                if (i_continuous_mode_sel)
                    cur_chan_r <= cur_chan_r + 2'd1;
                else
                    cur_chan_r <= next_chan_r;
            end
            if (start)
            begin
                // A start on continuous entry converts the shown channel
                conv_chan_r <= cont_entry ? next_chan_r + 2'd1
                    : cur_chan_r;
                if (!i_continuous_mode_sel)
                    next_chan_r <= {i_chan_addr_bit1, i_chan_addr_bit0};
            end
        end
    end

    // Analog mux select and power switch
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_analog_input_channel <= ACS_CHAN_RST;
            o_analog_power_en <= 1'b0;
        end
        else
        begin
            o_analog_input_channel <= (state_r == ACS_CONV) ? conv_chan_r
                : cur_chan_r;
            o_analog_power_en <= ~i_power_down_in;
        end
    end

    // Address pins as outputs, updated at busy rise or mode entry
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_chan_addr_oe <= 1'b0;
            o_chan_addr_bit0 <= 1'b0;
            o_chan_addr_bit1 <= 1'b0;
        end
        else
        begin
            o_chan_addr_oe <= i_continuous_mode_sel;
            if (cont_entry)
            begin
                o_chan_addr_bit0 <= ~next_chan_r[0];
                o_chan_addr_bit1 <= next_chan_r[1] ^ next_chan_r[0];
            end
            else if (conv_end && i_continuous_mode_sel)
            begin
                o_chan_addr_bit0 <= ~cur_chan_r[0];
                o_chan_addr_bit1 <= cur_chan_r[1] ^ cur_chan_r[0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Result capture; held untouched while no conversion ends
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            result_r <= ACS_RESULT_RST;
            result_chan_r <= ACS_CHAN_RST;
        end
        else if (conv_end)
        begin
            result_r <= i_sample_data; // no flag when powered down
            result_chan_r <= conv_chan_r;
        end
    end

    acs_result_mem u_mem
    (
        .i_clk(i_clk),
        .i_wr_en(conv_end),
        .i_wr_addr(conv_chan_r),
        .i_wr_data(i_sample_data),
        .i_rd_addr(i_avs_address[3:2]),
        .o_rd_data(mem_rd)
    );

    // Power-down width and settling counters
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pd_cnt_r <= '0;
            settle_r <= '0;
        end
        else
        begin
            if (!i_power_down_in)
                pd_cnt_r <= '0;
            else if (pd_cnt_r < ACS_TMR_W'(ACS_PD_MIN_CYC))
                pd_cnt_r <= pd_cnt_r + 1'b1;
            if (i_power_down_in)
                settle_r <= SETTLE_CYC;
            else if (settle_r != '0)
                settle_r <= settle_r - 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Avalon slave: fetch, then one cycle with waitrequest low
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bus_r <= ACS_BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            case (bus_r)
                ACS_BUS_IDLE:
                    if (bus_req)
                        bus_r <= ACS_BUS_FETCH;
                ACS_BUS_FETCH:
                begin
                    bus_r <= ACS_BUS_ACK;
                    o_avs_waitrequest <= 1'b0;
                    o_avs_readdata <= 32'h0000_0000;
                    if (i_avs_read)
                    begin
                        if (i_avs_address == ACS_REG_STATUS)
                        begin
                            o_avs_readdata[ACS_ST_BUSY] <= ~o_busy_n;
                            o_avs_readdata[ACS_ST_CONT] <= cont_r;
                            o_avs_readdata[ACS_ST_PD] <= pd_r;
                            o_avs_readdata[ACS_ST_SETTLE] <= settle_r != '0;
                            o_avs_readdata[ACS_ST_CHAN_LO +: 2] <= cur_chan_r;
                        end
                        else if (i_avs_address == ACS_REG_RESULT)
                            o_avs_readdata <= {14'h0000, result_chan_r,
                                result_r};
                        else if (i_avs_address >= ACS_REG_CHRES0
                            && i_avs_address <= ACS_REG_CHRES3
                            && i_avs_address[1:0] == 2'h0)
                            o_avs_readdata[15:0] <= mem_rd;
                    end
                end
                default:
                begin
                    bus_r <= ACS_BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end
endmodule : acs_sequencer

/* verif/acs_host_model.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Host side of the convert and channel pins
module acs_host_model
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_go,
    input wire logic i_hold,
    input wire logic [1:0] i_code,
    output logic o_cs_n,
    output logic o_read_conv_n,
    output logic [1:0] o_code
);
    logic [1:0] pulse_r;
    // Two cycles of convert strobe per request
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            pulse_r <= 2'h0;
        else if (i_go)
            pulse_r <= 2'h2;
        else if (pulse_r != 2'h0)
            pulse_r <= pulse_r - 2'h1;
    end
    // Held low for free-running conversions
    assign o_cs_n = !(i_hold || pulse_r != 2'h0);
    assign o_read_conv_n = o_cs_n;
    // Code for the following conversion
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_code <= 2'h0;
        else
            o_code <= i_code;
    end
endmodule : acs_host_model

/* verif/acs_seq_properties.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Port-level properties of the channel sequencer
module acs_seq_checker
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_read_conv_n,
    input wire logic i_continuous_mode_sel,
    input wire logic i_power_down_in,
    input wire logic o_chan_addr_bit0,
    input wire logic o_chan_addr_bit1,
    input wire logic o_chan_addr_oe,
    input wire logic o_busy_n,
    input wire logic o_analog_power_en,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    logic [8:0] low_cnt_r;
    wire logic [1:0] addr_w = {o_chan_addr_bit1, o_chan_addr_bit0};
    // Counts the cycles that busy stays low
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            low_cnt_r <= 9'h000;
        else if (!o_busy_n)
            low_cnt_r <= low_cnt_r + 9'h001;
        else
            low_cnt_r <= 9'h000;
    end
    // Fresh bus request and fresh pin convert command
    sequence bus_start;
        (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write);
    endsequence
    sequence conv_cmd;
        !i_cs_n && !i_read_conv_n && !$past(!i_cs_n && !i_read_conv_n);
    endsequence
    a_conv_start:
        assert property (conv_cmd ##0 o_busy_n |=> !o_busy_n)
        else $error("convert did not start");
    a_conv_length:
        assert property ($rose(o_busy_n) |-> low_cnt_r == 9'h190)
        else $error("busy low length wrong");
    a_addr_hold:
        assert property (o_chan_addr_oe && $past(o_chan_addr_oe)
            && $past(o_chan_addr_oe, 2) && !$rose(o_busy_n) |-> $stable(addr_w))
        else $error("address moved without busy rise");
    a_addr_step:
        assert property ($rose(o_busy_n) && $past(o_chan_addr_oe)
            |-> addr_w == 2'($past(addr_w) + 2'h1))
        else $error("address did not step");
    a_oe_mode:
        assert property (##1 o_chan_addr_oe == $past(i_continuous_mode_sel))
        else $error("address enable wrong");
    a_power_gate:
        assert property (i_power_down_in |=> !o_analog_power_en)
        else $error("analog left on in power-down");
    a_bus_answer:
        assert property (bus_start |-> ##[2:3] !o_avs_waitrequest)
        else $error("bus answer late");
    a_wait_pulse:
        assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_zero:
        assert property (!o_avs_waitrequest && i_avs_read
            && (i_avs_address[1:0] != 2'h0 || i_avs_address == 5'h0C)
            |-> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : acs_seq_checker

bind acs_sequencer acs_seq_checker u_chk
(
    .i_clk, .i_reset_n, .i_cs_n, .i_read_conv_n, .i_continuous_mode_sel,
    .i_power_down_in, .o_chan_addr_bit0, .o_chan_addr_bit1, .o_chan_addr_oe,
    .o_busy_n, .o_analog_power_en, .i_avs_address, .i_avs_read,
    .i_avs_write, .o_avs_readdata, .o_avs_waitrequest
);

/* verif/tb_top.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the channel sequencer
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module tb_top
    import acs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0, hold = 1'b0, cont = 1'b0, pd = 1'b0, rd = 1'b0;
    logic wr = 1'b0;
    logic [1:0] code = 2'h0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic cs_n, rc_n, a0, a1, oe, busy_n, pwr_en, wreq;
    logic [1:0] hcode, ach;
    logic [31:0] rdata, val, r;
    int mismatches = 0, checked = 0;
    acs_sequencer #(.SETTLE_CYC(16'h0014)) dut
    (
        .i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_read_conv_n(rc_n),
        .i_continuous_mode_sel(cont), .i_power_down_in(pd),
        .i_chan_addr_bit0(oe ? a0 : hcode[0]),
        .i_chan_addr_bit1(oe ? a1 : hcode[1]),
        .o_chan_addr_bit0(a0), .o_chan_addr_bit1(a1), .o_chan_addr_oe(oe),
        .o_busy_n(busy_n), .i_sample_data({14'h2B3C, ach}),
        .o_analog_input_channel(ach), .o_analog_power_en(pwr_en),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq)
    );
    acs_host_model host
    (
        .i_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_hold(hold),
        .i_code(code), .o_cs_n(cs_n), .o_read_conv_n(rc_n), .o_code(hcode)
    );
    // Clock at 50 MHz
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
            mismatches++;
    endtask : bus
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (busy_n !== v && n < 600)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 600)
            mismatches++;
    endtask : wait_busy
    task automatic conv(input logic [1:0] c);
        @(posedge clk);
        code <= c;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : conv
    task automatic t_reset();
        `CHK(oe, 1'b0)
        `CHK(pwr_en, 1'b1)
        bus(1'b1, 5'h0C, 32'hFFFF_FFFF, val);
        bus(1'b0, 5'h0C, 32'h0000_0000, val);
        `CHK(val, 32'h0000_0000)
        bus(1'b1, ACS_REG_RESULT, 32'hFFFF_FFFF, val);
        bus(1'b0, ACS_REG_RESULT, 32'h0000_0000, val);
        `CHK(val[15:0], ACS_RESULT_RST)
    endtask : t_reset
    task automatic t_manual();
        conv(2'h2);
        wait_busy(1'b0);
        conv(2'h3);
        wait_busy(1'b1);
        tick(2);
        `CHK(ach, 2'h2)
        conv(2'h1);
        wait_busy(1'b0);
        tick(2);
        `CHK(ach, 2'h2)
        wait_busy(1'b1);
        bus(1'b0, ACS_REG_RESULT, 32'h0000_0000, val);
        `CHK(val[17:0], {2'h2, 14'h2B3C, 2'h2})
        bus(1'b1, ACS_REG_CONTROL, 32'h0000_0001, val);
        wait_busy(1'b0);
        wait_busy(1'b1);
        bus(1'b0, ACS_REG_CHRES0 + 5'h04, 32'h0000_0000, val);
        `CHK(val[15:0], {14'h2B3C, 2'h1})
    endtask : t_manual
    task automatic t_cont();
        logic [1:0] exp;
        @(posedge clk);
        cont <= 1'b1;
        hold <= 1'b1;
        tick(3);
        exp = 2'h2;
        `CHK({a1, a0}, exp)
        repeat (4)
        begin
            wait_busy(1'b0);
            wait_busy(1'b1);
            exp = exp + 2'h1;
            `CHK({a1, a0}, exp)
            bus(1'b0, ACS_REG_RESULT, 32'h0000_0000, val);
            `CHK(val[17:0], {exp - 2'h1, 14'h2B3C, exp - 2'h1})
        end
        cont <= 1'b0;
        hold <= 1'b0;
        tick(2);
        wait_busy(1'b1);
    endtask : t_cont
    task automatic t_pd();
        bus(1'b0, ACS_REG_RESULT, 32'h0000_0000, r);
        pd <= 1'b1;
        tick(12);
        `CHK(pwr_en, 1'b0)
        bus(1'b0, ACS_REG_RESULT, 32'h0000_0000, val);
        `CHK(val, r)
        pd <= 1'b0;
        tick(2);
        bus(1'b0, ACS_REG_STATUS, 32'h0000_0000, val);
        `CHK(val[ACS_ST_SETTLE], 1'b1)
        `CHK(val[5:4], ACS_CHAN_RST)
        tick(25);
        bus(1'b0, ACS_REG_STATUS, 32'h0000_0000, val);
        `CHK(val[ACS_ST_SETTLE], 1'b0)
        pd <= 1'b1;
        bus(1'b1, ACS_REG_CONTROL, 32'h0000_0001, val);
        wait_busy(1'b0);
        bus(1'b0, ACS_REG_STATUS, 32'h0000_0000, val);
        `CHK(val[2:0], 3'h5)
        wait_busy(1'b1);
        pd <= 1'b0;
    endtask : t_pd
    task automatic complete_run();
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // Watchdog against a hung handshake
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        tick(3);
        rst_n <= 1'b1;
        tick(2);
        t_reset();
        t_manual();
        t_cont();
        t_pd();
        complete_run();
    end
endmodule : tb_top
